/* File: rtl/gia_flag_if.sv */
// Interface carrying I2C interrupt flag events, clears and state between aggregator and flag holder.
`timescale 1ns/1ps
interface gia_flag_if;
    logic [2:0] setEvt;
    logic [2:0] clrMask;
    logic [2:0] flags;
    modport ctrl (output setEvt, output clrMask, input flags);
    modport hold (input setEvt, input clrMask, output flags);
endinterface : gia_flag_if

/* File: rtl/gia_i2c_flags.sv */
// Sticky I2C completion and error flags, cleared by writing one.
`timescale 1ns/1ps
module gia_i2c_flags
    import gia_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    gia_flag_if.hold  fl
);
    logic [2:0] flags_q;
    logic [2:0] flags_d;

    // A new event in the clearing cycle keeps its flag set so it is never lost.
    assign flags_d = (flags_q & ~fl.clrMask) | fl.setEvt;
    assign fl.flags = flags_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            flags_q <= 3'h0;
        else
            flags_q <= flags_d;
    end

    property p_set_wins;
        @(posedge ref_clk) disable iff (sys_rst)
        (|fl.setEvt) |=> ((flags_q & $past(fl.setEvt)) == $past(fl.setEvt));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("I2C flag event lost.");

    property p_clear_works;
        @(posedge ref_clk) disable iff (sys_rst)
        (fl.clrMask[I2C_DONE_BIT] && !fl.setEvt[I2C_DONE_BIT]) |=> !flags_q[I2C_DONE_BIT];
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("Done flag not cleared.");
endmodule : gia_i2c_flags

/* File: rtl/gia_pkg.sv */
// Package with register map, field positions and response codes of the global interrupt aggregator.
package gia_pkg;
    localparam int          ADDR_W          = 32;
    localparam int          DATA_W          = 32;
    localparam int          PORT_N          = 8;
    localparam int          I2C_FLAG_N      = 3;
    localparam logic [31:0] STATUS_ADDR     = 32'h0001AC00;
    localparam logic [31:0] ENABLE_ADDR     = 32'h0001AC04;
    localparam logic [31:0] I2C_FLAG_ADDR   = 32'h0001AC10;
    localparam logic [31:0] ENABLE_RESET    = 32'h00000000;
    localparam logic [31:0] GLOBAL_MASK     = 32'hFF0000D0;
    localparam logic [2:0]  I2C_FLAG_MASK   = 3'h7;
    localparam int          RESET_SYM_BIT   = 4;
    localparam int          I2C_BIT         = 6;
    localparam int          FABRIC_ERR_BIT  = 7;
    localparam int          PORT_BASE_BIT   = 24;
    localparam int          I2C_DONE_BIT    = 0;
    localparam int          I2C_CFG_BIT     = 1;
    localparam int          I2C_NOACK_BIT   = 2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : gia_pkg

/* File: rtl/gia_top.sv */
// Global interrupt aggregator: live status, enable gate, I2C flags and AXI4-Lite slave.
// Functional notes
// - Each status bit is the OR of its source requests; read-only, zero at reset.
// - Status bit 4 shows the combined reset-symbol event from all ports.
// - Status bit 7 shows a fabric transfer error.
// - Status bits 24 to 31 show ports 7 down to 0.
// - A request reaches the interrupt pin only when its enable bit is set.
// - Enable bits 4 and 7 gate reset-symbol and fabric-error interrupts; reset zero.
// - Enable bit 6 gates the I2C interrupt; status bit 6 shows it.
// - Enable bits 24 to 31 gate ports 7 down to 0; reset zero.
// - I2C source is the OR of done, config-error and no-ack flags, cleared by writing one.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module gia_top
    import gia_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [PORT_N-1:0] portEvent,
    input  wire logic              resetSymbolEvent,
    input  wire logic              fabricTransferError,
    input  wire logic              i2cDoneEvent,
    input  wire logic              i2cConfigError,
    input  wire logic              noAckError,
    output logic                   intOut_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    gia_flag_if flagBus ();

    gia_i2c_flags u_flags (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .fl      (flagBus.hold)
    );

    logic [31:0]       enable_q;
    logic [31:0]       statusVec;
    logic [PORT_N-1:0] portRev;
    logic              i2cIrq;
    logic              awHave_q, wHave_q, bvalid_q, awRdy_q, wRdy_q;
    logic              awHave_d, wHave_d, bvalid_d, awRdy_d, wRdy_d;
    logic [ADDR_W-1:0] awAddr_q;
    logic [DATA_W-1:0] wData_q;
    logic [3:0]        wStrb_q;
    logic [1:0]        bresp_q;
    logic              arRdy_q, arRdy_d, rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic              intN_q;
    logic              doWrite, arTake;
    logic [31:0]       byteMask, enable_d;
    logic              wrEnable, wrFlags, wrMapped, rdMapped;
    logic [DATA_W-1:0] rdMux;

    // Port n lands on status bit 31-n.
    genvar gi;
    generate
        for (gi = 0; gi < PORT_N; gi++)
        begin : g_port
            assign portRev[gi] = portEvent[PORT_N-1-gi];
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_strb
            assign byteMask[8*gi +: 8] = {8{wStrb_q[gi]}};
        end
    endgenerate

    assign flagBus.setEvt = {noAckError, i2cConfigError, i2cDoneEvent};
    assign i2cIrq = |flagBus.flags;

    // Purely combinational so the status follows its sources with no stale copy.
    assign statusVec = {portRev, 16'h0000,
                        fabricTransferError, i2cIrq, 1'h0, resetSymbolEvent, 4'h0};

    assign doWrite  = awHave_q && wHave_q && !bvalid_q;
    assign wrEnable = doWrite && (awAddr_q == ENABLE_ADDR);
    assign wrFlags  = doWrite && (awAddr_q == I2C_FLAG_ADDR);
    assign wrMapped = (awAddr_q == ENABLE_ADDR) || (awAddr_q == I2C_FLAG_ADDR) || (awAddr_q == STATUS_ADDR);
    assign flagBus.clrMask = wrFlags && wStrb_q[0] ? (wData_q[2:0] & I2C_FLAG_MASK) : 3'h0;
    assign enable_d = wrEnable ? (((enable_q & ~byteMask) | (wData_q & byteMask)) & GLOBAL_MASK)
                               : enable_q;

    assign awHave_d = awHave_q ? !doWrite : (s_axi_awvalid && awRdy_q);
    assign wHave_d  = wHave_q ? !doWrite : (s_axi_wvalid && wRdy_q);
    assign bvalid_d = doWrite || (bvalid_q && !s_axi_bready);
    assign awRdy_d  = !awHave_d && !bvalid_d;
    assign wRdy_d   = !wHave_d && !bvalid_d;

    assign arTake   = s_axi_arvalid && arRdy_q;
    assign rdMapped = (s_axi_araddr == STATUS_ADDR) || (s_axi_araddr == ENABLE_ADDR)
                   || (s_axi_araddr == I2C_FLAG_ADDR);
    assign rdMux    = (s_axi_araddr == STATUS_ADDR)   ? statusVec :
                      (s_axi_araddr == ENABLE_ADDR)   ? enable_q :
                      (s_axi_araddr == I2C_FLAG_ADDR) ? {29'h0, flagBus.flags} : 32'h00000000;
    assign rvalid_d = arTake || (rvalid_q && !s_axi_rready);
    assign arRdy_d  = !rvalid_d;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            bvalid_q <= 1'b0;
            awRdy_q  <= 1'b0;
            wRdy_q   <= 1'b0;
            awAddr_q <= 32'h00000000;
            wData_q  <= 32'h00000000;
            wStrb_q  <= 4'h0;
            bresp_q  <= RESP_OKAY;
            enable_q <= ENABLE_RESET;
        end
        else
        begin
            awHave_q <= awHave_d;
            wHave_q  <= wHave_d;
            bvalid_q <= bvalid_d;
            awRdy_q  <= awRdy_d;
            wRdy_q   <= wRdy_d;
            if (s_axi_awvalid && awRdy_q)
                awAddr_q <= s_axi_awaddr;
            if (s_axi_wvalid && wRdy_q)
            begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
                bresp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            arRdy_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end
        else
        begin
            arRdy_q  <= arRdy_d;
            rvalid_q <= rvalid_d;
            if (arTake)
            begin
                rdata_q <= rdMux;
                rresp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // The pin is registered, so it trails the sources by one clock.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            intN_q <= 1'b1;
        else
            intN_q <= !(|(statusVec & enable_q));
    end

    assign intOut_n      = intN_q;
    assign s_axi_awready = awRdy_q;
    assign s_axi_wready  = wRdy_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arRdy_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    logic statusRead;
    assign statusRead = arTake && (s_axi_araddr == STATUS_ADDR);

    property p_status_live;
        @(posedge ref_clk) disable iff (sys_rst)
        statusRead |=> (s_axi_rvalid && s_axi_rdata == $past(statusVec));
    endproperty
    a_status_live: assert property (p_status_live) else $error("Status read differs from sources.");

    property p_reset_sym;
        @(posedge ref_clk) disable iff (sys_rst)
        (statusRead && resetSymbolEvent) |=> s_axi_rdata[RESET_SYM_BIT];
    endproperty
    a_reset_sym: assert property (p_reset_sym) else $error("Reset-symbol bit missing.");

    property p_fabric_err;
        @(posedge ref_clk) disable iff (sys_rst)
        statusRead |=> (s_axi_rdata[FABRIC_ERR_BIT] == $past(fabricTransferError));
    endproperty
    a_fabric_err: assert property (p_fabric_err) else $error("Fabric error bit wrong.");

    property p_port_order;
        @(posedge ref_clk) disable iff (sys_rst)
        statusRead |=> (s_axi_rdata[31] == $past(portEvent[0]) && s_axi_rdata[24] == $past(portEvent[7]));
    endproperty
    a_port_order: assert property (p_port_order) else $error("Port bit order wrong.");

    property p_gate_closed;
        @(posedge ref_clk) disable iff (sys_rst)
        (enable_q == 32'h00000000) |=> intOut_n;
    endproperty
    a_gate_closed: assert property (p_gate_closed) else $error("Pin low with all enables clear.");

    property p_pin_level;
        @(posedge ref_clk) disable iff (sys_rst)
        ##1 (intOut_n == !$past(|(statusVec & enable_q)));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("Pin level does not match gated status.");

    property p_enable_write;
        @(posedge ref_clk) disable iff (sys_rst)
        (wrEnable && wStrb_q == 4'hF) |=> (enable_q == ($past(wData_q) & GLOBAL_MASK));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("Enable write not stored.");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        ((enable_q & ~GLOBAL_MASK) == 32'h00000000) && ((statusVec & ~GLOBAL_MASK) == 32'h00000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

    property p_i2c_bit;
        @(posedge ref_clk) disable iff (sys_rst)
        statusRead |=> (s_axi_rdata[I2C_BIT] == $past(|flagBus.flags));
    endproperty
    a_i2c_bit: assert property (p_i2c_bit) else $error("I2C status bit wrong.");

    property p_clears_with_source;
        @(posedge ref_clk) disable iff (sys_rst)
        (statusRead && !resetSymbolEvent && !fabricTransferError && portEvent == 8'h00 && !i2cIrq)
            |=> (s_axi_rdata == 32'h00000000);
    endproperty
    a_clears_with_source: assert property (p_clears_with_source) else $error("Status kept stale bits.");

    property p_cov_write;
        @(posedge ref_clk) disable iff (sys_rst) s_axi_bvalid && s_axi_bready;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_read;
        @(posedge ref_clk) disable iff (sys_rst) statusRead;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_irq;
        @(posedge ref_clk) disable iff (sys_rst) $fell(intOut_n);
    endproperty
    c_cov_irq: cover property (p_cov_irq);
endmodule : gia_top

/* File: test/gia_host_model.sv */
// Host processor model that watches the active-low interrupt pin of the aggregator.
`timescale 1ns/1ps
module gia_host_model
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       intOut_n,
    output logic            irqSeen,
    output logic [7:0]      irqCount
);
    logic       irqSeen_q;
    logic [7:0] irqCount_q;

    // The host samples the pin as a level once per clock and counts each new low level as one interrupt.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            irqSeen_q  <= 1'h0;
            irqCount_q <= 8'h0;
        end
        else
        begin
            irqSeen_q <= !intOut_n;
            if (!intOut_n && !irqSeen_q)
                irqCount_q <= irqCount_q + 8'h1;
        end
    end
    assign irqSeen  = irqSeen_q;
    assign irqCount = irqCount_q;
endmodule : gia_host_model

/* File: test/tb_global_interrupt_aggregator.sv */
// Self-checking bench for the global interrupt aggregator over AXI4-Lite.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_global_interrupt_aggregator
    import gia_pkg::*;
;
    logic              ref_clk = 1'h0;
    logic              sys_rst = 1'h1;
    logic [PORT_N-1:0] portEvent = '0;
    logic              resetSymbolEvent = 1'h0, fabricTransferError = 1'h0;
    logic              i2cDoneEvent = 1'h0, i2cConfigError = 1'h0, noAckError = 1'h0;
    logic              intOut_n, awready, wready, bvalid, arready, rvalid, irqSeen;
    logic [1:0]        bresp, rresp;
    logic [31:0]       awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0]        irqCount;
    logic [3:0]        wstrb = 4'hF;
    int                err_total = 0, check_count = 0;

    gia_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .portEvent(portEvent),
        .resetSymbolEvent(resetSymbolEvent), .fabricTransferError(fabricTransferError),
        .i2cDoneEvent(i2cDoneEvent), .i2cConfigError(i2cConfigError), .noAckError(noAckError),
        .intOut_n(intOut_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    gia_host_model u_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .intOut_n(intOut_n),
        .irqSeen(irqSeen), .irqCount(irqCount));

    initial
    begin
        forever #5 ref_clk = !ref_clk;
    end

    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic dn;
        dn = 1'h0;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (!dn)
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid)
            begin
                bready <= 1'h0;
                dn = 1'h1;
                `CHK(bresp, er)
            end
        end
    endtask : axiWrite

    task automatic axiRead(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic dn;
        dn = 1'h0;
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        while (!dn)
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid)
            begin
                rready <= 1'h0;
                dn = 1'h1;
                `CHK(rdata, ed)
                `CHK(rresp, er)
            end
        end
    endtask : axiRead

    task automatic endTest(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask : endTest

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // The tests need under 200 cycles; the limit of 20000 cycles leaves a wide margin before a hang is declared.
    initial
    begin
        #200000;
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        `CHK(intOut_n, 1'h1)
        axiRead(STATUS_ADDR, 32'h0, RESP_OKAY);
        axiRead(ENABLE_ADDR, ENABLE_RESET, RESP_OKAY);
        axiWrite(ENABLE_ADDR, 32'hFFFFFFFF, RESP_OKAY);
        axiRead(ENABLE_ADDR, GLOBAL_MASK, RESP_OKAY);
        axiWrite(STATUS_ADDR, 32'hFFFFFFFF, RESP_OKAY);
        axiRead(STATUS_ADDR, 32'h0, RESP_OKAY);
        axiRead(32'h0001AC08, 32'h0, RESP_SLVERR);
        axiWrite(32'h0001AC08, 32'h1, RESP_SLVERR);
        endTest("registers");
        for (int i = 0; i < PORT_N; i++)
        begin
            portEvent <= 8'h1 << i;
            axiRead(STATUS_ADDR, 32'h1 << (31 - i), RESP_OKAY);
        end
        {fabricTransferError, resetSymbolEvent, portEvent} <= 10'h100;
        axiRead(STATUS_ADDR, 32'h10, RESP_OKAY);
        {fabricTransferError, resetSymbolEvent} <= 2'h2;
        axiRead(STATUS_ADDR, 32'h80, RESP_OKAY);
        fabricTransferError <= 1'h0;
        axiRead(STATUS_ADDR, 32'h0, RESP_OKAY);
        endTest("mapping");
        axiWrite(ENABLE_ADDR, 32'h0, RESP_OKAY);
        portEvent <= 8'h81;
        repeat (3) @(posedge ref_clk);
        `CHK(irqSeen, 1'h0)
        axiWrite(ENABLE_ADDR, 32'h01000000, RESP_OKAY);
        repeat (3) @(posedge ref_clk);
        `CHK(irqSeen, 1'h1)
        portEvent <= 8'h0;
        repeat (3) @(posedge ref_clk);
        `CHK(irqSeen, 1'h0)
        endTest("gating");
        axiWrite(ENABLE_ADDR, 32'h40, RESP_OKAY);
        for (int k = 0; k < I2C_FLAG_N; k++)
        begin
            {noAckError, i2cConfigError, i2cDoneEvent} <= 3'h1 << k;
            @(posedge ref_clk);
            {noAckError, i2cConfigError, i2cDoneEvent} <= 3'h0;
            axiRead(I2C_FLAG_ADDR, 32'h1 << k, RESP_OKAY);
            axiRead(STATUS_ADDR, 32'h40, RESP_OKAY);
            `CHK(irqSeen, 1'h1)
            axiWrite(I2C_FLAG_ADDR, 32'h1 << k, RESP_OKAY);
            axiRead(STATUS_ADDR, 32'h0, RESP_OKAY);
        end
        repeat (3) @(posedge ref_clk);
        `CHK(irqCount, 8'h5)
        endTest("i2c");
        // Byte strobes limit an enable write to the lanes that are marked.
        wstrb <= 4'h8;
        axiWrite(ENABLE_ADDR, 32'hFFFFFFFF, RESP_OKAY);
        wstrb <= 4'hF;
        axiRead(ENABLE_ADDR, 32'hFF000040, RESP_OKAY);
        wstrb <= 4'h1;
        axiWrite(ENABLE_ADDR, 32'h00000000, RESP_OKAY);
        wstrb <= 4'hF;
        axiRead(ENABLE_ADDR, 32'hFF000000, RESP_OKAY);
        endTest("strobes");
        conclude();
    end
endmodule : tb_global_interrupt_aggregator
